// [cdsc_ctrl.sv]
// channel divider mode, spread modulation and supply select control
`timescale 1ns/100ps
`default_nettype none
module cdsc_ctrl (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic        fod_tick_in,
   input  wire logic        ref_tick_in,
   input  wire logic        fod_cycle_end_in,
   output logic [15:0]      reg_rdata_out,
   output logic             divider_delay_mode_out,
   output logic             divider_register_bypass_out,
   output logic             divider_reset_out,
   output logic             spread_counter_clock_source_out,
   output logic             spread_type_out,
   output logic [1:0]       spread_magnitude_out,
   output logic             spread_enable_out,
   output logic             glitch_free_switch_enable_out,
   output logic             low_supply_select_out,
   output logic [9:0]       spread_mod_count_out,
   output logic             spread_mod_down_out,
   output logic             spread_period_end_out
);
   // ****************************************************************
   // register file
   // ****************************************************************
   logic [15:0] ctrl;
   logic [15:0] supply;
   logic [15:0] applied;
   logic [2:0]  presc_cnt;
   logic [9:0]  mod_cnt;
   logic        mod_down;
   logic        period_end;
   logic        wr_ctrl;
   logic        wr_supply;
   logic        pending;
   logic        apply_now;
   logic        cnt_src_tick;
   logic        mod_tick;
   logic [9:0]  period_len;
   logic [9:0]  period_last;

   assign wr_ctrl   = reg_wr_in && (reg_addr_in == cdsc_pkg::OFS_DIV_MOD_CTRL);
   assign wr_supply = reg_wr_in && (reg_addr_in == cdsc_pkg::OFS_SUPPLY_SEL);

   // writable words, reserved bits kept as written
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl   <= cdsc_pkg::RST_DIV_MOD_CTRL;
         supply <= cdsc_pkg::RST_SUPPLY_SEL;
      end else begin
         if (wr_ctrl) begin
            ctrl <= reg_wdata_in;
         end
         if (wr_supply) begin
            supply <= reg_wdata_in;
         end
      end
   end

   // read port, unmapped offsets read zero
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            cdsc_pkg::OFS_DIV_MOD_CTRL: reg_rdata_out <= ctrl;
            cdsc_pkg::OFS_SUPPLY_SEL:   reg_rdata_out <= supply;
            default:                    reg_rdata_out <= 16'h0000;
         endcase
      end
   end

   // ****************************************************************
   // update policy
   // ****************************************************************
   // glitch-free waits for the divider cycle boundary
   assign pending   = (ctrl != applied);
   assign apply_now = pending && fod_tick_in &&
                      (!ctrl[cdsc_pkg::BIT_GLITCH_FREE] ||
                       fod_cycle_end_in);

   // applied copy that steers the divider and modulation
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         applied <= cdsc_pkg::RST_DIV_MOD_CTRL;
      end else if (apply_now) begin
         applied <= ctrl;
      end
   end

   // mode outputs straight from the applied copy, glitch-free enable and supply select straight from the written words
   assign divider_delay_mode_out = applied[cdsc_pkg::BIT_DELAY_MODE];
   assign divider_register_bypass_out = applied[cdsc_pkg::BIT_BYPASS];
   assign divider_reset_out = applied[cdsc_pkg::BIT_DIV_RESET];
   assign spread_counter_clock_source_out = applied[cdsc_pkg::BIT_CNT_SRC];
   assign spread_type_out = applied[cdsc_pkg::BIT_SPREAD_TYPE];
   assign spread_magnitude_out =
      applied[cdsc_pkg::POS_MAG_HI:cdsc_pkg::POS_MAG_LO];
   assign spread_enable_out = applied[cdsc_pkg::BIT_SPREAD_EN];
   assign glitch_free_switch_enable_out = ctrl[cdsc_pkg::BIT_GLITCH_FREE];
   assign low_supply_select_out = supply[cdsc_pkg::BIT_LOW_SUPPLY];
   assign spread_mod_count_out = mod_cnt;
   assign spread_mod_down_out = mod_down;
   assign spread_period_end_out = period_end;

   // ****************************************************************
   // modulation counter
   // ****************************************************************
   // counter clock source select
   assign cnt_src_tick = applied[cdsc_pkg::BIT_CNT_SRC] ?
                         ref_tick_in : fod_tick_in;
   assign mod_tick = cnt_src_tick &&
      (presc_cnt == applied[cdsc_pkg::POS_CNT_DIV_HI:cdsc_pkg::POS_CNT_DIV_LO]);

   // period length lookup
   always_comb begin
      case (applied[cdsc_pkg::POS_PERIOD_HI:cdsc_pkg::POS_PERIOD_LO])
         2'd0:    period_len = cdsc_pkg::PERIOD_CODE0;
         2'd1:    period_len = cdsc_pkg::PERIOD_CODE1;
         2'd2:    period_len = cdsc_pkg::PERIOD_CODE2;
         default: period_len = cdsc_pkg::PERIOD_CODE3;
      endcase
   end
   assign period_last = period_len - 10'h001;

   // prescaler divides the counter clock by field value plus one
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         presc_cnt <= 3'h0;
      end else if (!spread_enable_out) begin
         presc_cnt <= 3'h0;
      end else if (apply_now) begin
         presc_cnt <= 3'h0;
      end else if (mod_tick) begin
         presc_cnt <= 3'h0;
      end else if (cnt_src_tick) begin
         presc_cnt <= presc_cnt + 3'h1;
      end
   end

   // triangle position over one modulation period
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mod_cnt    <= 10'h000;
         mod_down   <= 1'b0;
         period_end <= 1'b0;
      end else if (!spread_enable_out) begin
         mod_cnt    <= 10'h000;
         mod_down   <= 1'b0;
         period_end <= 1'b0;
      end else begin
         period_end <= mod_tick && (mod_cnt >= period_last);
         if (mod_tick) begin
            if (mod_cnt >= period_last) begin
               mod_cnt  <= 10'h000;
               mod_down <= 1'b0;
            end else begin
               mod_cnt  <= mod_cnt + 10'h001;
               mod_down <= ((mod_cnt + 10'h001) >= {1'b0, period_len[9:1]});
            end
         end
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   property p_delay_mode;
      apply_now |=> divider_delay_mode_out ==
         $past(ctrl[cdsc_pkg::BIT_DELAY_MODE]);
   endproperty
   a_delay_mode: assert property (p_delay_mode) else $error("delay mode");

   property p_bypass_reset;
      apply_now |=> (divider_register_bypass_out ==
                     $past(ctrl[cdsc_pkg::BIT_BYPASS])) &&
                    (divider_reset_out ==
                     $past(ctrl[cdsc_pkg::BIT_DIV_RESET]));
   endproperty
   a_bypass_reset: assert property (p_bypass_reset) else $error("bypass");

   property p_src_hold;
      spread_enable_out && !apply_now &&
         applied[cdsc_pkg::BIT_CNT_SRC] && !ref_tick_in
         |=> $stable(presc_cnt);
   endproperty
   a_src_hold: assert property (p_src_hold) else $error("source");

   property p_presc_limit;
      spread_enable_out |-> presc_cnt <=
         applied[cdsc_pkg::POS_CNT_DIV_HI:cdsc_pkg::POS_CNT_DIV_LO];
   endproperty
   a_presc_limit: assert property (p_presc_limit) else $error("divide");

   property p_spread;
      apply_now |=> (spread_type_out ==
                     $past(ctrl[cdsc_pkg::BIT_SPREAD_TYPE])) &&
                    (spread_magnitude_out ==
                     $past(ctrl[cdsc_pkg::POS_MAG_HI:cdsc_pkg::POS_MAG_LO]));
   endproperty
   a_spread: assert property (p_spread) else $error("spread");

   property p_period;
      spread_period_end_out |-> mod_cnt == 10'h000 &&
         $past(mod_cnt) == $past(period_last);
   endproperty
   a_period: assert property (p_period) else $error("period");

   property p_glitch_wait;
      pending && ctrl[cdsc_pkg::BIT_GLITCH_FREE] && !fod_cycle_end_in
         |=> $stable(applied);
   endproperty
   a_glitch_wait: assert property (p_glitch_wait) else $error("glitch");

   property p_supply;
      wr_supply |=> low_supply_select_out ==
         $past(reg_wdata_in[cdsc_pkg::BIT_LOW_SUPPLY]);
   endproperty
   a_supply: assert property (p_supply) else $error("supply");

   property p_readback;
      wr_ctrl ##1 (reg_rd_in && !wr_ctrl &&
                   reg_addr_in == cdsc_pkg::OFS_DIV_MOD_CTRL)
         |=> reg_rdata_out == $past(reg_wdata_in, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("readback");

   property p_immediate;
      pending && !ctrl[cdsc_pkg::BIT_GLITCH_FREE] && fod_tick_in
         |=> applied == $past(ctrl);
   endproperty
   a_immediate: assert property (p_immediate) else $error("apply");

   c_period_end: cover property (spread_period_end_out);
   c_glitch_apply: cover property
      (apply_now && ctrl[cdsc_pkg::BIT_GLITCH_FREE]);
   c_ref_source: cover property
      (mod_tick && applied[cdsc_pkg::BIT_CNT_SRC]);
endmodule
`default_nettype wire

// [cdsc_ctrl_tb_top.sv]
// self-checking testbench for the channel divider and spread control block
`timescale 1ns/100ps
`default_nettype none
module cdsc_ctrl_tb_top;
   logic        clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in;
   logic        fod_tick_in, ref_tick_in, fod_cycle_end_in;
   logic [7:0]  reg_addr_in;
   logic [15:0] reg_wdata_in, reg_rdata_out, w, last;
   logic        dly, byp, drst, src, typ, en, gf, low, down, pend;
   logic [1:0]  mag;
   logic [9:0]  cnt;
   int          n_errors, checked, cycles, n_pend, n, k, p;
   // ****************************************************************
   // device under test
   // ****************************************************************
   cdsc_ctrl i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .fod_tick_in(fod_tick_in), .ref_tick_in(ref_tick_in),
      .fod_cycle_end_in(fod_cycle_end_in), .reg_rdata_out(reg_rdata_out),
      .divider_delay_mode_out(dly), .divider_register_bypass_out(byp),
      .divider_reset_out(drst), .spread_counter_clock_source_out(src),
      .spread_type_out(typ), .spread_magnitude_out(mag),
      .spread_enable_out(en), .glitch_free_switch_enable_out(gf),
      .low_supply_select_out(low), .spread_mod_count_out(cnt),
      .spread_mod_down_out(down), .spread_period_end_out(pend));
   // ****************************************************************
   // clock, cycle limit and period-end pulse count
   // ****************************************************************
   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cycles++;
      if (pend === 1'b1) n_pend++;
      if (cycles == 40000) begin
         n_errors++;
         finish_test();
      end
   end
   // applied fields expected for a control word
   function automatic logic [15:0] exp_mode(input logic [15:0] v);
      return {7'h00, v[15:12], v[8:6], v[3], v[0]};
   endfunction
   function automatic logic [15:0] got_mode();
      return {7'h00, dly, byp, drst, src, typ, mag, en, gf};
   endfunction
   // ****************************************************************
   // compare, bus and tick tasks
   // ****************************************************************
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_count(input int got, input int exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   // write then read back in the very next cycle
   task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 chk_word(reg_rdata_out, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1 chk_word(reg_rdata_out, exp);
   endtask
   task automatic tick(input logic f, input logic r, input logic e);
      @(posedge clk_sys_in);
      fod_tick_in <= f;
      ref_tick_in <= r;
      fod_cycle_end_in <= e;
      @(posedge clk_sys_in);
      {fod_tick_in, ref_tick_in, fod_cycle_end_in} <= 3'b000;
      @(posedge clk_sys_in);
      #1;
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {rst_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
      {fod_tick_in, ref_tick_in, fod_cycle_end_in} = 3'b000;
      {n_errors, checked, cycles, n_pend} = '0;
      void'($urandom(32'h23b3));
      repeat (16) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      #1 chk_word(got_mode(), exp_mode(16'h0071));
      chk_word({15'h0000, low}, 16'h0001);
      rd(8'h39, 16'h0071);
      rd(8'h3A, 16'h0008);
      rd(8'h3B, 16'h0000);
      // immediate policy, random words, all bits read back
      for (k = 0; k < 24; k++) begin
         w = 16'($urandom) & 16'hFFFE;
         wr_rd(8'h39, w);
         tick(1'b1, 1'b0, 1'b0);
         chk_word(got_mode(), exp_mode(w));
         rd(8'h39, w);
         last = w;
         w = 16'($urandom);
         wr(8'h3A, w);
         #1 chk_word({15'h0000, low}, {15'h0000, w[3]});
         rd(8'h3A, w);
      end
      wr(8'h3B, 16'hFFFF);
      rd(8'h39, last);
      // glitch-free policy waits for the cycle boundary
      for (k = 0; k < 8; k++) begin
         w = {~last[15], 15'($urandom)} | 16'h0001;
         wr(8'h39, w);
         tick(1'b1, 1'b0, 1'b0);
         chk_word(got_mode(), exp_mode(last) | 16'h0001);
         tick(1'b1, 1'b0, 1'b1);
         chk_word(got_mode(), exp_mode(w));
         last = w & 16'hFFFE;
         wr(8'h39, last);
         tick(1'b1, 1'b0, 1'b0);
      end
      // modulation period per code, source and division
      for (k = 0; k < 4; k++) begin
         w = {3'b000, k[0], 2'b00, k[1], 3'b001, k[1:0], 4'h0};
         p = (k == 0) ? 240 : (k == 1) ? 400 : (k == 2) ? 520 : 556;
         wr(8'h39, w);
         tick(1'b1, 1'b0, 1'b0);
         wr(8'h39, w | 16'h0008);
         tick(1'b1, 1'b0, 1'b0);
         n_pend = 0;
         n = 0;
         while (n_pend == 0 && n < 1200) begin
            tick(~k[0], k[0], 1'b0);
            n++;
            chk_word({15'h0, down}, {15'h0, cnt >= p / 2});
         end
         chk_count(n, (k[1] + 1) * p);
         chk_count(n_pend, 1);
      end
      // two reference ticks at division two advance the count once
      tick(1'b0, 1'b1, 1'b0);
      tick(1'b0, 1'b1, 1'b0);
      chk_word({6'h00, cnt}, 16'h0001);
      wr(8'h39, 16'h0031);
      tick(1'b1, 1'b0, 1'b1);
      tick(1'b1, 1'b1, 1'b0);
      chk_word({6'h00, cnt}, 16'h0000);
      finish_test();
   end
endmodule
`default_nettype wire

// [cdsc_pkg.sv]
// constants for the channel divider and spread control block
package cdsc_pkg;
   // ****************************************************************
   // register offsets and widths
   // ****************************************************************
   localparam int unsigned ADDR_W          = 8;
   localparam int unsigned DATA_W          = 16;
   localparam logic [7:0]  OFS_DIV_MOD_CTRL = 8'h39;
   localparam logic [7:0]  OFS_SUPPLY_SEL   = 8'h3A;
   localparam logic [15:0] RST_DIV_MOD_CTRL = 16'h0071;
   localparam logic [15:0] RST_SUPPLY_SEL   = 16'h0008;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int unsigned BIT_DELAY_MODE  = 15;
   localparam int unsigned BIT_BYPASS      = 14;
   localparam int unsigned BIT_DIV_RESET   = 13;
   localparam int unsigned BIT_CNT_SRC     = 12;
   localparam int unsigned POS_CNT_DIV_HI  = 11;
   localparam int unsigned POS_CNT_DIV_LO  = 9;
   localparam int unsigned BIT_SPREAD_TYPE = 8;
   localparam int unsigned POS_MAG_HI      = 7;
   localparam int unsigned POS_MAG_LO      = 6;
   localparam int unsigned POS_PERIOD_HI   = 5;
   localparam int unsigned POS_PERIOD_LO   = 4;
   localparam int unsigned BIT_SPREAD_EN   = 3;
   localparam int unsigned BIT_GLITCH_FREE = 0;
   localparam int unsigned BIT_LOW_SUPPLY  = 3;

   // ****************************************************************
   // modulation period lengths in counter cycles
   // ****************************************************************
   localparam int unsigned MOD_W           = 10;
   localparam logic [9:0]  PERIOD_CODE0    = 10'h0F0;
   localparam logic [9:0]  PERIOD_CODE1    = 10'h190;
   localparam logic [9:0]  PERIOD_CODE2    = 10'h208;
   localparam logic [9:0]  PERIOD_CODE3    = 10'h22C;
endpackage
